// ---- rsc_top.sv ----
// reset source controller: combines reset sources and records their cause
//
// Operation
// - any device reset clears the program counter
// - power-on presets port data and direction
// - illegal guard value resets after guard delay
// - guard loads 55h; legal values do nothing
// - guard reset sets guard flag bit 3
// - cause flag bits 7 to 4 read zero
// - flags set by hardware, cleared by software zero
// - brownout active in fast and slow modes
// - brownout disabled in sleep and idle
// - low supply must outlast filter time
// - brownout reset sets brownout flag bit 2
// - decode brownout level code to threshold
// - bad level code resets, restores select
// - bad level code sets flag bit 1
// - genuine brownout keeps select register
// - brownout select loads 66h at power-on
// - flash control write 55h resets immediately
// - running watchdog timeout resets, sets timeout
// - bad watchdog guard resets, sets bit 0
// - sleeping watchdog timeout clears pc and sp
// - power-on clears timeout and powerdown flags
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
#(
  parameter int GUARD_DELAY = RSC_GUARD_DELAY_CYC,
  parameter int FILTER_LEN = RSC_FILTER_CYC,
  parameter int DEVRST_LEN = RSC_DEVRST_CYC
)
(
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // axi4-lite slave
  input wire logic [3:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [3:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  // device side
  input wire logic [1:0] I_MODE,
  input wire logic I_LOW_SUPPLY,
  input wire logic I_WDT_TIMEOUT,
  input wire logic [4:0] I_WDT_GUARD_CODE,
  input wire logic I_FLASH_CTRL_WR,
  input wire logic [7:0] I_FLASH_CTRL_DATA,
  input wire logic I_HALT,
  input wire logic I_CLR_WDT,
  output logic O_DEV_RST,
  output logic O_PC_CLEAR,
  output logic O_SP_CLEAR,
  output logic O_PORT_PRESET,
  output logic O_BO_ENABLE,
  output logic [2:0] O_BO_THRESHOLD,
  output logic O_TIMEOUT_FLAG,
  output logic O_POWERDOWN_FLAG
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] guard_reg; // reset_guard_register
  logic [7:0] bosel_reg; // brownout_select_register
  rsc_flags_s flags_reg; // reset_cause_flags
  logic to_reg; // timeout status flag
  logic pdf_reg; // powerdown flag
  logic [15:0] rst_cnt_reg; // device reset width counter
  logic pend_reg; // guard delay running
  logic [15:0] pend_cnt_reg; // guard delay counter
  logic [2:0] pend_src_reg; // faults seen: guard, level, watchdog
  logic [15:0] bo_cnt_reg; // brownout filter counter
  logic part_rst_reg; // pc and sp clear pulse from sleep timeout
  logic aw_full_reg; // write address held
  logic [3:0] aw_addr_reg;
  logic w_full_reg; // write data held
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic rd_flags_reg; // last read hit the flag register

  logic dev_rst; // device reset active
  logic run_mode; // fast or slow
  logic guard_bad;
  logic lvl_bad;
  logic wdt_bad;
  logic lvl_off;
  logic pend_expire;
  logic bo_active;
  logic bo_fire;
  logic flash_fire;
  logic wdt_full;
  logic wdt_part;
  logic full_trig;
  logic bo_only;
  logic wr_fire;
  logic wr_ok;
  logic [3:0] clr_mask; // flags that software writes to zero
  logic [31:0] rd_word;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // fault and event detection
  assign dev_rst = (rst_cnt_reg != 16'h0000);
  assign run_mode = (I_MODE == RSC_MODE_FAST) || (I_MODE == RSC_MODE_SLOW);
  // legal guard values cause no action
  assign guard_bad = (guard_reg != RSC_GUARD_OK_A) && (guard_reg != RSC_GUARD_OK_B);
  assign wdt_bad = (I_WDT_GUARD_CODE != RSC_WDG_OK_A) &&
                   (I_WDT_GUARD_CODE != RSC_WDG_OK_B);
  assign lvl_off = (bosel_reg == RSC_LVL_OFF);

  // level code decode; unknown codes flag a threshold fault
  always_comb
  begin
    lvl_bad = 1'b0;
    O_BO_THRESHOLD = RSC_TH_1V70;
    case (bosel_reg)
      RSC_LVL_1V70: O_BO_THRESHOLD = RSC_TH_1V70;
      RSC_LVL_1V90: O_BO_THRESHOLD = RSC_TH_1V90;
      RSC_LVL_2V55: O_BO_THRESHOLD = RSC_TH_2V55;
      RSC_LVL_3V15: O_BO_THRESHOLD = RSC_TH_3V15;
      RSC_LVL_3V80: O_BO_THRESHOLD = RSC_TH_3V80;
      RSC_LVL_OFF: O_BO_THRESHOLD = RSC_TH_1V70;
      default: lvl_bad = 1'b1;
    endcase
  end

  // brownout watches only while running with a defined, enabled level
  assign bo_active = run_mode && !lvl_off && !lvl_bad && !dev_rst;
  assign O_BO_ENABLE = bo_active;
  assign bo_fire = bo_active && I_LOW_SUPPLY &&
                   (bo_cnt_reg == 16'(FILTER_LEN - 1));
  assign pend_expire = pend_reg && !dev_rst &&
                       (pend_cnt_reg == 16'(GUARD_DELAY - 1));
  assign flash_fire = I_FLASH_CTRL_WR && !dev_rst &&
                      (I_FLASH_CTRL_DATA == RSC_FLASH_RST);
  assign wdt_full = I_WDT_TIMEOUT && run_mode && !dev_rst;
  assign wdt_part = I_WDT_TIMEOUT && !run_mode && !dev_rst;
  assign full_trig = pend_expire || bo_fire || flash_fire || wdt_full;
  // a brownout alone keeps the level selection
  assign bo_only = bo_fire && !pend_expire && !flash_fire && !wdt_full;

  ////////////////////////////////////////////////////////////////////////////
  // device reset width; power-on holds it for DEVRST_LEN edges after release
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      rst_cnt_reg <= 16'(DEVRST_LEN);
    else if (full_trig)
      rst_cnt_reg <= 16'(DEVRST_LEN);
    else if (dev_rst)
      rst_cnt_reg <= rst_cnt_reg - 16'h0001;
  end

  assign O_DEV_RST = dev_rst;
  assign O_PC_CLEAR = dev_rst || part_rst_reg;
  assign O_SP_CLEAR = dev_rst || part_rst_reg;
  // ports return to inputs with data and direction high on every full reset
  assign O_PORT_PRESET = dev_rst;

  // one-cycle pc and sp clear for a timeout while asleep
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      part_rst_reg <= 1'b0;
    else
      part_rst_reg <= wdt_part;
  end

  ////////////////////////////////////////////////////////////////////////////
  // guard delay: once started it runs out even if software repairs the code
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      pend_reg <= 1'b0;
      pend_cnt_reg <= 16'h0000;
      pend_src_reg <= 3'h0;
    end
    else if (full_trig || dev_rst)
    begin
      pend_reg <= 1'b0;
      pend_cnt_reg <= 16'h0000;
      pend_src_reg <= 3'h0;
    end
    else if (pend_reg || guard_bad || lvl_bad || wdt_bad)
    begin
      pend_reg <= 1'b1;
      pend_cnt_reg <= pend_reg ? pend_cnt_reg + 16'h0001 : 16'h0000;
      pend_src_reg <= pend_src_reg | {guard_bad, lvl_bad, wdt_bad};
    end
  end

  // brownout filter: any return to good supply restarts the count
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      bo_cnt_reg <= 16'h0000;
    else if (!bo_active || !I_LOW_SUPPLY || bo_fire)
      bo_cnt_reg <= 16'h0000;
    else
      bo_cnt_reg <= bo_cnt_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel
  assign O_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign O_AXI_WREADY = !w_full_reg && !bvalid_reg;
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_ok = (aw_addr_reg == RSC_OFS_GUARD) || (aw_addr_reg == RSC_OFS_FLAGS) ||
                 (aw_addr_reg == RSC_OFS_BOSEL) || (aw_addr_reg == RSC_OFS_STAT);
  assign O_AXI_BVALID = bvalid_reg;
  assign O_AXI_BRESP = bresp_reg;

  // address and data are latched separately, in either order
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RSC_RESP_OKAY;
    end
    else
    begin
      if (I_AXI_AWVALID && O_AXI_AWREADY)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {I_AXI_AWADDR[3:2], 2'b00};
      end
      if (I_AXI_WVALID && O_AXI_WREADY)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= I_AXI_WDATA;
        w_strb_reg <= I_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RSC_RESP_OKAY : RSC_RESP_DECERR;
      end
      else if (bvalid_reg && I_AXI_BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  // software zeros in the low byte clear flags; ones are ignored
  assign clr_mask = (wr_fire && aw_addr_reg == RSC_OFS_FLAGS && w_strb_reg[0]) ?
                    ~w_data_reg[3:0] : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // guard and select registers; full resets restore the guard, and the select unless a brownout alone
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      guard_reg <= RSC_GUARD_POR;
    else if (full_trig)
      guard_reg <= RSC_GUARD_POR;
    else if (wr_fire && aw_addr_reg == RSC_OFS_GUARD && w_strb_reg[0])
      guard_reg <= w_data_reg[7:0];
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      bosel_reg <= RSC_BOSEL_POR;
    else if (full_trig && !bo_only)
      bosel_reg <= RSC_BOSEL_POR;
    else if (wr_fire && aw_addr_reg == RSC_OFS_BOSEL && w_strb_reg[0] && !full_trig)
      bosel_reg <= w_data_reg[7:0];
  end

  // cause flags survive every reset but power-on; a set beats a clear
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      flags_reg <= '0;
    else
    begin
      flags_reg.guard <= (pend_expire && (pend_src_reg[2] || guard_bad)) ||
                         (flags_reg.guard && !clr_mask[RSC_BIT_GUARD]);
      flags_reg.brownout <= bo_fire ||
                            (flags_reg.brownout && !clr_mask[RSC_BIT_BO]);
      flags_reg.thr_fault <= (pend_expire && (pend_src_reg[1] || lvl_bad)) ||
                             (flags_reg.thr_fault && !clr_mask[RSC_BIT_THR]);
      flags_reg.wdt_fault <= (pend_expire && (pend_src_reg[0] || wdt_bad)) ||
                             (flags_reg.wdt_fault && !clr_mask[RSC_BIT_WDT]);
    end
  end

  // timeout and powerdown flags; brownout leaves them alone
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      to_reg <= 1'b0;
      pdf_reg <= 1'b0;
    end
    else
    begin
      to_reg <= wdt_full || wdt_part || to_reg;
      pdf_reg <= wdt_part || I_HALT || (pdf_reg && !I_CLR_WDT);
    end
  end

  assign O_TIMEOUT_FLAG = to_reg;
  assign O_POWERDOWN_FLAG = pdf_reg;

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel, answer one cycle after the address is taken
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({I_AXI_ARADDR[3:2], 2'b00})
      RSC_OFS_GUARD: rd_word = {24'h00_0000, guard_reg};
      RSC_OFS_FLAGS: rd_word = {28'h000_0000, flags_reg};
      RSC_OFS_BOSEL: rd_word = {24'h00_0000, bosel_reg};
      RSC_OFS_STAT: rd_word = {27'h000_0000, pend_reg, bo_active, lvl_bad, pdf_reg, to_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  assign O_AXI_ARREADY = !rvalid_reg;
  assign O_AXI_RVALID = rvalid_reg;
  assign O_AXI_RDATA = rdata_reg;
  assign O_AXI_RRESP = rresp_reg;

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RSC_RESP_OKAY;
      rd_flags_reg <= 1'b0;
    end
    else if (I_AXI_ARVALID && O_AXI_ARREADY)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RSC_RESP_OKAY : RSC_RESP_DECERR;
      rd_flags_reg <= ({I_AXI_ARADDR[3:2], 2'b00} == RSC_OFS_FLAGS);
    end
    else if (rvalid_reg && I_AXI_RREADY)
      rvalid_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_fault_seen;
    !pend_reg && !dev_rst && !full_trig && (guard_bad || lvl_bad || wdt_bad);
  endsequence

  sequence s_delay_armed;
    pend_reg && (pend_cnt_reg == 16'h0000);
  endsequence

  a_guard_delay_start: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_fault_seen |=> s_delay_armed)
    else $error("guard delay did not start on an illegal code");

  a_guard_expire_rst: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    pend_expire |=> O_DEV_RST && (guard_reg == RSC_GUARD_POR))
    else $error("guard delay expiry gave no device reset");

  a_guard_flag_set: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (pend_expire && guard_bad) |=> flags_reg.guard)
    else $error("guard reset flag not set");

  a_flag_no_hw_clr: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (flags_reg.brownout && clr_mask[RSC_BIT_BO] == 1'b0) |=> flags_reg.brownout)
    else $error("brownout flag lost without a software clear");

  a_flags_upper_zero: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (rvalid_reg && rd_flags_reg) |-> (O_AXI_RDATA[31:4] == 28'h000_0000))
    else $error("cause flag upper bits not zero");

  a_bo_idle_off: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !run_mode |-> !bo_fire ##1 (bo_cnt_reg == 16'h0000))
    else $error("brownout active outside fast or slow mode");

  // looks back at the supply itself, but only at the first and last cycle of the filter time, not the cycles between
  a_bo_filter_len: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    bo_fire |-> I_LOW_SUPPLY && $past(I_LOW_SUPPLY && bo_active, FILTER_LEN - 1))
    else $error("brownout fired before the filter time");

  a_bo_flag_keep_sel: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    bo_only |=> flags_reg.brownout && (bosel_reg == $past(bosel_reg)) && O_DEV_RST)
    else $error("brownout reset flag or select register wrong");

  a_thr_fault_restore: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (pend_expire && lvl_bad) |=> flags_reg.thr_fault && (bosel_reg == RSC_BOSEL_POR))
    else $error("threshold fault did not restore select");

  a_flash_reset: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    flash_fire |=> O_DEV_RST && O_PC_CLEAR)
    else $error("flash control write gave no reset");

  a_wdt_sleep_part: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    wdt_part |=> O_PC_CLEAR && O_SP_CLEAR && to_reg && pdf_reg ##1 !part_rst_reg)
    else $error("sleep timeout handling wrong");

endmodule

// ---- rsc_pkg.sv ----
// package: constants and types for the reset source controller
package rsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets (aligned 32-bit words)
  localparam logic [3:0] RSC_OFS_GUARD = 4'h0; // reset_guard_register
  localparam logic [3:0] RSC_OFS_FLAGS = 4'h4; // reset_cause_flags
  localparam logic [3:0] RSC_OFS_BOSEL = 4'h8; // brownout_select_register
  localparam logic [3:0] RSC_OFS_STAT = 4'hC; // read-only status

  // reset values
  localparam logic [7:0] RSC_GUARD_POR = 8'h55;
  localparam logic [7:0] RSC_BOSEL_POR = 8'h66;

  // legal guard codes
  localparam logic [7:0] RSC_GUARD_OK_A = 8'h55;
  localparam logic [7:0] RSC_GUARD_OK_B = 8'hAA;
  localparam logic [4:0] RSC_WDG_OK_A = 5'h15;
  localparam logic [4:0] RSC_WDG_OK_B = 5'h0A;

  // brownout level codes
  localparam logic [7:0] RSC_LVL_1V70 = 8'h66;
  localparam logic [7:0] RSC_LVL_1V90 = 8'h55;
  localparam logic [7:0] RSC_LVL_2V55 = 8'h33;
  localparam logic [7:0] RSC_LVL_3V15 = 8'h99;
  localparam logic [7:0] RSC_LVL_3V80 = 8'hAA;
  localparam logic [7:0] RSC_LVL_OFF = 8'hF0;

  // flash control value that resets the device
  localparam logic [7:0] RSC_FLASH_RST = 8'h55;

  // cause flag bit positions
  localparam int RSC_BIT_WDT = 0;
  localparam int RSC_BIT_THR = 1;
  localparam int RSC_BIT_BO = 2;
  localparam int RSC_BIT_GUARD = 3;

  // operating mode encoding on the mode input
  localparam logic [1:0] RSC_MODE_FAST = 2'h0;
  localparam logic [1:0] RSC_MODE_SLOW = 2'h1;
  localparam logic [1:0] RSC_MODE_IDLE = 2'h2;
  localparam logic [1:0] RSC_MODE_SLEEP = 2'h3;

  // axi responses
  localparam logic [1:0] RSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSC_RESP_DECERR = 2'h3;

  // timing counts in cycles of the 40 ns clock
  localparam int RSC_GUARD_DELAY_CYC = 16; // guard reset delay
  localparam int RSC_FILTER_CYC = 8; // brownout filter time
  localparam int RSC_DEVRST_CYC = 4; // width of the device reset

  // threshold selection as seen by the analog comparator
  typedef enum logic [2:0]
  {
    RSC_TH_1V70,
    RSC_TH_1V90,
    RSC_TH_2V55,
    RSC_TH_3V15,
    RSC_TH_3V80
  } rsc_thresh_e;

  // sticky cause flags, bit 3 down to bit 0
  typedef struct packed
  {
    logic guard;
    logic brownout;
    logic thr_fault;
    logic wdt_fault;
  } rsc_flags_s;

endpackage

// ---- rsc_top_bench.sv ----
// self-checking bench for the reset source controller
`timescale 1ns/1ps
module rsc_top_bench;
  import rsc_pkg::*;
  ////////////////////////////////////////
  // short counts keep the run brief
  localparam int GD = 6; // guard reset delay
  localparam int FL = 4; // brownout filter length
  localparam int DR = 3; // device reset width
  // one table row: register write and the outputs it should give
  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdat;
    logic [2:0] thr;
    logic en;
  } rsc_row_s;
  logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, r;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, mode;
  logic low_sup, wdt_to, fl_wr, halt, clr_wdt;
  logic [4:0] wdt_guard;
  logic [7:0] fl_data;
  logic dev_rst, pc_clear, sp_clear, port_preset, bo_en, to_flag, pd_flag;
  logic [2:0] bo_thr;
  int failures = 0;
  int tests_run = 0;
  int c;
  rsc_row_s rows [9] = '{
    '{4'h8, 8'h66, 3'h0, 1'b1}, '{4'h8, 8'h55, 3'h1, 1'b1}, '{4'h8, 8'h33, 3'h2, 1'b1},
    '{4'h8, 8'h99, 3'h3, 1'b1}, '{4'h8, 8'hAA, 3'h4, 1'b1}, '{4'h8, 8'hF0, 3'h0, 1'b0},
    '{4'h8, 8'h66, 3'h0, 1'b1}, '{4'h0, 8'hAA, 3'h0, 1'b1}, '{4'h0, 8'h55, 3'h0, 1'b1}};
  rsc_top #(.GUARD_DELAY(GD), .FILTER_LEN(FL), .DEVRST_LEN(DR)) i_dut (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_MODE(mode), .I_LOW_SUPPLY(low_sup), .I_WDT_TIMEOUT(wdt_to),
    .I_WDT_GUARD_CODE(wdt_guard), .I_FLASH_CTRL_WR(fl_wr), .I_FLASH_CTRL_DATA(fl_data),
    .I_HALT(halt), .I_CLR_WDT(clr_wdt), .O_DEV_RST(dev_rst), .O_PC_CLEAR(pc_clear),
    .O_SP_CLEAR(sp_clear), .O_PORT_PRESET(port_preset), .O_BO_ENABLE(bo_en),
    .O_BO_THRESHOLD(bo_thr), .O_TIMEOUT_FLAG(to_flag), .O_POWERDOWN_FLAG(pd_flag));
  // 25 MHz clock
  always #20 clk = ~clk;
  ////////////////////////////////////////
  // verdict and end of run, the only exit
  task automatic summarize();
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  // bounds every wait so a hang ends in the report
  task automatic tick(inout int n);
    n++;
    if (n > 60)
    begin
      failures++;
      summarize();
    end
  endtask
  // ready is sampled mid-cycle, where it is settled, so the handshake
  // edge that follows is known without racing the design
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    int n;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_p || w_p)
    begin
      @(negedge clk);
      if (awready === 1'b1)
        aw_p = 1'b0;
      if (wready === 1'b1)
        w_p = 1'b0;
      @(posedge clk);
      if (!aw_p)
        awvalid <= 1'b0;
      if (!w_p)
        wvalid <= 1'b0;
      tick(n);
    end
    do
    begin
      @(negedge clk);
      tick(n);
    end
    while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, RSC_RESP_OKAY});
    @(posedge clk);
    bready <= 1'b0;
  endtask
  // read one register, data taken at the falling edge where rvalid is seen
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      tick(n);
    end
    while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do
    begin
      @(negedge clk);
      tick(n);
    end
    while (rvalid !== 1'b1);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, RSC_RESP_OKAY});
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // counts falling clock edges until the device reset reaches a level
  task automatic wait_rst(input logic lvl, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge clk);
      tick(cnt);
    end
    while (dev_rst !== lvl);
  endtask
  // power-on reset held three cycles
  task automatic por();
    int k;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({28'h0, dev_rst, port_preset, pc_clear, sp_clear}, 32'hF);
    arst_n <= 1'b1;
    wait_rst(1'b0, k);
    // the low level shows at the half-cycle after the last counted edge
    chk(32'(k), 32'(DR + 1));
  endtask
  // read a register and compare
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    axi_rd(a, r);
    chk(r, e);
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'hF;
    {mode, low_sup, wdt_to, fl_wr, halt, clr_wdt, fl_data} = '0;
    wdt_guard = RSC_WDG_OK_A;
    por();
    rd_chk(RSC_OFS_GUARD, 32'h55);
    rd_chk(RSC_OFS_FLAGS, 32'h0);
    rd_chk(RSC_OFS_BOSEL, 32'h66);
    chk({30'h0, to_flag, pd_flag}, 32'h0);
    // legal codes: read back, decoded threshold, no reset follows
    foreach (rows[i])
    begin
      axi_wr(rows[i].addr, {24'h0, rows[i].wdat});
      repeat (GD + 4) @(posedge clk);
      rd_chk(rows[i].addr, {24'h0, rows[i].wdat});
      chk({28'h0, bo_thr, bo_en}, {28'h0, rows[i].thr, rows[i].en});
      chk({31'h0, dev_rst}, 32'h0);
    end
    // software cannot set a cause flag
    axi_wr(RSC_OFS_FLAGS, 32'hFF);
    rd_chk(RSC_OFS_FLAGS, 32'h0);
    // illegal guard value
    axi_wr(RSC_OFS_GUARD, 32'h12);
    wait_rst(1'b1, c);
    chk({31'h0, c >= GD && c <= GD + 3}, 32'h1);
    wait_rst(1'b0, c);
    rd_chk(RSC_OFS_GUARD, 32'h55);
    rd_chk(RSC_OFS_FLAGS, 32'h08);
    // undefined level code resets and restores the select value
    axi_wr(RSC_OFS_BOSEL, 32'h12);
    wait_rst(1'b1, c);
    chk({31'h0, c >= GD && c <= GD + 3}, 32'h1);
    wait_rst(1'b0, c);
    rd_chk(RSC_OFS_BOSEL, 32'h66);
    rd_chk(RSC_OFS_FLAGS, 32'h0A);
    // brownout ignored while asleep
    axi_wr(RSC_OFS_BOSEL, 32'h99);
    mode <= RSC_MODE_SLEEP;
    low_sup <= 1'b1;
    repeat (FL + 4) @(posedge clk);
    chk({30'h0, dev_rst, bo_en}, 32'h0);
    // a dip one cycle short of the filter is ignored
    mode <= RSC_MODE_SLOW;
    low_sup <= 1'b0;
    @(posedge clk);
    low_sup <= 1'b1;
    repeat (FL - 1) @(posedge clk);
    low_sup <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, dev_rst}, 32'h0);
    low_sup <= 1'b1;
    wait_rst(1'b1, c);
    @(posedge clk);
    low_sup <= 1'b0;
    chk({31'h0, c >= FL && c <= FL + 2}, 32'h1);
    wait_rst(1'b0, c);
    rd_chk(RSC_OFS_FLAGS, 32'h0E);
    rd_chk(RSC_OFS_BOSEL, 32'h99);
    chk({30'h0, to_flag, pd_flag}, 32'h0);
    // flash control: other value does nothing, 55h resets at once
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clk);
      fl_wr <= 1'b1;
      fl_data <= (v == 0) ? 8'h54 : RSC_FLASH_RST;
      @(posedge clk);
      fl_wr <= 1'b0;
    end
    chk({31'h0, dev_rst}, 32'h0);
    wait_rst(1'b1, c);
    chk({31'h0, c <= 2}, 32'h1);
    wait_rst(1'b0, c);
    // running watchdog timeout, powerdown flag left as it was
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    wait_rst(1'b1, c);
    chk({31'h0, c <= 2}, 32'h1);
    wait_rst(1'b0, c);
    chk({30'h0, to_flag, pd_flag}, 32'h3);
    rd_chk(RSC_OFS_BOSEL, 32'h66);
    clr_wdt <= 1'b1;
    @(posedge clk);
    clr_wdt <= 1'b0;
    // idle-mode timeout clears only pc and sp for one cycle
    mode <= RSC_MODE_IDLE;
    @(posedge clk);
    chk({30'h0, to_flag, pd_flag}, 32'h2);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    @(negedge clk);
    chk({29'h0, pc_clear, sp_clear, dev_rst}, 32'h6);
    @(negedge clk);
    chk({29'h0, pc_clear, sp_clear, dev_rst}, 32'h0);
    chk({30'h0, to_flag, pd_flag}, 32'h3);
    @(posedge clk);
    mode <= RSC_MODE_FAST;
    // second legal watchdog code, then a one-cycle glitch that is repaired
    wdt_guard <= RSC_WDG_OK_B;
    repeat (GD + 4) @(posedge clk);
    chk({31'h0, dev_rst}, 32'h0);
    wdt_guard <= 5'h03;
    @(posedge clk);
    wdt_guard <= RSC_WDG_OK_A;
    wait_rst(1'b1, c);
    chk({31'h0, c >= GD - 1 && c <= GD + 3}, 32'h1);
    wait_rst(1'b0, c);
    rd_chk(RSC_OFS_FLAGS, 32'h0F);
    // zero bits clear, one bits leave the flag alone
    axi_wr(RSC_OFS_FLAGS, 32'h0B);
    rd_chk(RSC_OFS_FLAGS, 32'h0B);
    axi_wr(RSC_OFS_FLAGS, 32'h0);
    rd_chk(RSC_OFS_FLAGS, 32'h0);
    // second power-on in mid-run
    axi_wr(RSC_OFS_GUARD, 32'hAA);
    por();
    chk({30'h0, to_flag, pd_flag}, 32'h0);
    rd_chk(RSC_OFS_GUARD, 32'h55);
    summarize();
  end
endmodule
